/* File: pkg/mtc_pkg.sv */
// Purpose: Shared constants and types of the multi-channel timer core
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Channel block n sits at n*0x40, global block at index GLB_BLOCK
package mtc_pkg;

    typedef logic [31:0] mtc_word_t;        // Bus data word
    localparam int CNT_W = 16;              // Counter width
    typedef logic [CNT_W-1:0] mtc_cnt_t;    // Counter value
    localparam mtc_cnt_t CNT_MAX = 16'hffff; // Top value of the counter
    localparam mtc_cnt_t CNT_ZERO = 16'h0000; // Bottom value of the counter

    // Address decode
    localparam int ADDR_W = 12;             // Byte address width
    localparam int ADDR_CH_LSB = 6;         // Channel select field
    localparam int ADDR_IDX_LSB = 2;        // Word index field
    localparam logic [2:0] GLB_BLOCK = 3'h5; // Global register block

    // Per-channel word indices
    localparam logic [3:0] IDX_CTRL = 4'h0; // Mode and clock control
    localparam logic [3:0] IDX_IOC = 4'h1;  // io_level_control_reg
    localparam logic [3:0] IDX_IER = 4'h2;  // irq_enable_reg
    localparam logic [3:0] IDX_FLAG = 4'h3; // timer_flag_reg
    localparam logic [3:0] IDX_CNT = 4'h4;  // timer_count
    localparam logic [3:0] IDX_GRA = 4'h5;  // match_capture_reg A, then B..D
    localparam logic [3:0] IDX_LAST = 4'h8; // Last channel index

    // Global word indices
    localparam logic [3:0] GLB_START = 4'h0; // Start bits, one per channel
    localparam logic [3:0] GLB_PMODE = 4'h1; // PWM mode and cascade
    localparam logic [3:0] GLB_DEAD = 4'h2;  // dead_time_reg
    localparam logic [3:0] GLB_CDR = 4'h3;   // cycle_data_reg
    localparam logic [3:0] GLB_CBR = 4'h4;   // cycle_buffer_reg

    // Control field positions
    localparam int CTL_CAP_LSB = 4;         // Capture mode of A..D
    localparam int CTL_CLK_LSB = 8;         // Clock source
    localparam int CTL_CLR_LSB = 10;        // Clear source
    localparam int CTL_BUF_LSB = 12;        // buffer_a_select, buffer_b_select
    localparam int CTL_CAPINT = 14;         // Internal capture source
    localparam int CTL_W = 15;              // Implemented control bits
    localparam int PM_CASC = 2;             // Cascade bit in mode word
    localparam int IER_DMA = 7;             // DMA request enable for flag A
    localparam int FLAG_W = 6;              // Flags A..D, overflow, underflow
    localparam int FLG_OVF = 4;             // overflow_flag
    localparam int FLG_UDF = 5;             // underflow_flag

    typedef enum logic [1:0] {CLK_INT, CLK_RISE, CLK_BOTH, CLK_PHASE} mtc_clk_t;
    typedef enum logic [1:0] {CLR_NONE, CLR_A, CLR_B, CLR_SYNC} mtc_clr_t;
    typedef enum logic [1:0] {LVL_HOLD, LVL_LOW, LVL_HIGH, LVL_TOGGLE} mtc_lvl_t;
    typedef enum logic [1:0] {PM_NORMAL, PM_COMPL, PM_RSYNC, PM_SPARE} mtc_pmode_t;

endpackage

/* File: hw/mtc_chan.sv */
// Purpose: One timer channel: counter, four match/capture registers, flags
// Assumes: Count pulses and capture events come in as one-cycle strobes
// Notes: T1 is the APB setup cycle, T2 the access cycle
module mtc_chan #(
    parameter bit NEW_ON_T1 = 1'b0 // Buffer write in setup cycle is forwarded
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,                  // Counter input clock
    input wire logic down,                  // Count direction
    input wire logic cmp_strobe,            // Compare without counting
    input wire logic sync_clr,              // Clear from another channel
    input wire logic load_en,               // Forced counter load
    input wire mtc_pkg::mtc_cnt_t load_val,
    input wire logic buf_xfer,              // Buffer transfer from outside
    input wire logic [1:0] eff_buf,         // Buffer selects in force
    input wire logic [3:0] cap_evt,         // Capture strobes A..D
    input wire logic dma_ack,               // DMA served flag A
    input wire logic wr_t1,                 // Write setup cycle to us
    input wire logic wr_t2,                 // Write access cycle to us
    input wire logic rd_t2,                 // Read access cycle to us
    input wire logic [3:0] idx,
    input wire mtc_pkg::mtc_word_t wdata,
    output mtc_pkg::mtc_word_t rdata,
    output mtc_pkg::mtc_cnt_t cnt,
    output logic [mtc_pkg::CTL_W-1:0] ctrl,
    output logic match_a,
    output logic clr_own,
    output logic wrap,
    output logic pin_a,
    output logic pin_b,
    output logic irq,
    output logic dma_req
);
    import mtc_pkg::*;

    mtc_cnt_t cnt_r, cnt_nxt;               // Counter
    mtc_cnt_t gr_r [4];                     // Match/capture registers
    mtc_cnt_t gr_nxt [4];
    logic [CTL_W-1:0] ctrl_r;               // Control word
    logic [7:0] ioc_r, ier_r;               // Pin levels, enables
    logic [FLAG_W-1:0] flag_r, armed_r;     // Flags and read-as-one marks
    logic [FLAG_W-1:0] set_v, clr_v;
    logic pin_a_r, pin_b_r;
    logic [3:0] eq, match, capt, cap_mode, is_buf;
    logic wr_cnt, edge_hi, edge_lo;
    mtc_clr_t clr_sel;

    // Level after a compare match
    function automatic logic lvl(input logic cur, input logic [1:0] code);
        case (mtc_lvl_t'(code))
            LVL_LOW: lvl = 1'b0;
            LVL_HIGH: lvl = 1'b1;
            LVL_TOGGLE: lvl = ~cur;
            default: lvl = cur;
        endcase
    endfunction

    assign cap_mode = ctrl_r[CTL_CAP_LSB +: 4];
    assign clr_sel = mtc_clr_t'(ctrl_r[CTL_CLR_LSB +: 2]);
    assign is_buf = {eff_buf, 2'b00};       // C and D may act as buffers
    assign wr_cnt = wr_t2 && idx == IDX_CNT;
    assign edge_hi = cnt_r == CNT_MAX;
    assign edge_lo = cnt_r == CNT_ZERO;

    // Match only in the last state before the count moves on
    genvar g;
    for (g = 0; g < 4; g++) begin : g_cmp
        assign eq[g] = cnt_r == gr_r[g];
        assign match[g] = (tick || cmp_strobe) && eq[g] && !cap_mode[g] && !is_buf[g];
        assign capt[g] = cap_evt[g] && cap_mode[g] && !is_buf[g];
    end

    // Own clear source; the sync clear is kept apart to avoid a loop
    assign clr_own = (clr_sel == CLR_A && (match[0] || capt[0])) ||
                     (clr_sel == CLR_B && (match[1] || capt[1]));
    assign wrap = tick && (down ? edge_lo : edge_hi);

    // Counter next value: load, clear, write, count
    always_comb begin
        cnt_nxt = cnt_r;
        if (load_en)
            cnt_nxt = load_val;
        else if (clr_own || sync_clr)
            cnt_nxt = CNT_ZERO;
        else if (wr_cnt)
            cnt_nxt = wdata[CNT_W-1:0];
        else if (tick)
            cnt_nxt = down ? cnt_r - 1'b1 : cnt_r + 1'b1;
    end

    // Register updates; later branches take priority
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gr_nxt[i] = gr_r[i];
            if (wr_t2 && idx == IDX_GRA + 4'(i))
                gr_nxt[i] = wdata[CNT_W-1:0];
            if (i < 2 && eff_buf[i & 1] && (match[i] || buf_xfer)) begin
                // Channel 0 takes the value written in the same setup cycle
                if (NEW_ON_T1 && wr_t1 && idx == IDX_GRA + 4'(i + 2))
                    gr_nxt[i] = wdata[CNT_W-1:0];
                else
                    gr_nxt[i] = gr_r[(i + 2) & 3];
            end
            if (capt[i])
                gr_nxt[i] = cnt_r;
            if (i >= 2 && is_buf[i] && capt[i & 1])
                gr_nxt[i] = gr_r[i & 1];
        end
    end

    // Flag set and clear; a new event beats a clear in the same cycle
    assign set_v = {wrap && down && !clr_own && !sync_clr && !wr_cnt && !load_en,
                    wrap && !down && !clr_own && !sync_clr && !wr_cnt && !load_en,
                    match | capt};
    assign clr_v = ((wr_t2 && idx == IDX_FLAG) ? (armed_r & ~wdata[FLAG_W-1:0]) : '0) |
                   {{(FLAG_W-1){1'b0}}, dma_ack};

    // Read path; capture in the access cycle is forwarded
    always_comb begin
        rdata = '0;
        case (idx)
            IDX_CTRL: rdata[CTL_W-1:0] = ctrl_r;
            IDX_IOC: rdata[7:0] = ioc_r;
            IDX_IER: rdata[7:0] = ier_r;
            IDX_FLAG: rdata[FLAG_W-1:0] = flag_r;
            IDX_CNT: rdata[CNT_W-1:0] = cnt_r;
            default: begin
                if (idx >= IDX_GRA && idx <= IDX_LAST)
                    rdata[CNT_W-1:0] = (|capt) ? gr_nxt[idx[1:0] - 2'd1] : gr_r[idx[1:0] - 2'd1];
            end
        endcase
    end

    // State flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= CNT_ZERO;
            gr_r <= '{default: CNT_MAX};
            ctrl_r <= '0;
            ioc_r <= '0;
            ier_r <= '0;
            flag_r <= '0;
            armed_r <= '0;
            pin_a_r <= 1'b0;
            pin_b_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            gr_r <= gr_nxt;
            if (wr_t2 && idx == IDX_CTRL)
                ctrl_r <= wdata[CTL_W-1:0];
            if (wr_t2 && idx == IDX_IOC)
                ioc_r <= wdata[7:0];
            if (wr_t2 && idx == IDX_IER)
                ier_r <= wdata[7:0];
            flag_r <= set_v | (flag_r & ~clr_v);
            armed_r <= ((rd_t2 && idx == IDX_FLAG) ? (armed_r | flag_r) : armed_r) & ~clr_v;
            if (match[0])
                pin_a_r <= lvl(pin_a_r, ioc_r[1:0]);
            if (match[1])
                pin_b_r <= lvl(pin_b_r, ioc_r[3:2]);
        end
    end

    assign cnt = cnt_r;
    assign ctrl = ctrl_r;
    assign match_a = match[0];
    assign pin_a = pin_a_r;
    assign pin_b = pin_b_r;
    assign irq = |(flag_r & ier_r[FLAG_W-1:0]);
    assign dma_req = flag_r[0] && ier_r[IER_DMA];
endmodule

/* File: hw/mtc_core.sv */
// Purpose: Five-channel timer core with APB register access
// Assumes: pclk 200 MHz, pins synchronous to pclk, pready always high
// Notes: Setup cycle is T1, access cycle is T2; channels 3/4 pair for PWM
//
// Overview of operation
// - Match pulse once, in last equal state
// - Match A/B drives pin A/B to programmed level
// - Flag clears by write-0 after read, or DMA (flag A only)
// - Clear on match gives period N+1
// - Clear beats counter write in T2
// - Counter write beats increment in T2
// - Compare write and match both happen
// - Buffer write in T1: ch0 new, ch3/4 old
// - Read in T2 returns captured value
// - Capture beats register write in T2
// - Buffer transfer beats buffer write in T2
// - Cascade upper write wins, lower still compares
// - Complementary stop loads dead time and zero
// - Complementary buffers follow channel 3 select
// - Channel 4 buffer-A kills its C pin
// - Reset-sync buffering follows ch3, no C/D flags
// - Channel 3 start runs both, ch3 clock
// - Top value clear sets no overflow flag
// - Clear beats overflow and underflow flags
// - Counter write suppresses overflow/underflow flags
// - Flag and enable raise interrupt request
//
// Design decisions made here: the APB interface to the registers and the address map.
module mtc_core #(
    parameter int NCH = 5 // Channel count
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mtc_pkg::ADDR_W-1:0] paddr,
    input wire mtc_pkg::mtc_word_t pwdata,
    output mtc_pkg::mtc_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clk_a,
    input wire logic ext_clk_b,
    input wire logic [4*NCH-1:0] cap_pin,
    input wire logic [NCH-1:0] dma_ack,
    output logic [NCH-1:0] dma_req,
    output logic [NCH-1:0] irq,
    output logic [NCH-1:0] timer_io_pin_a,
    output logic [NCH-1:0] timer_io_pin_b,
    output logic ch4_c_output_pin
);
    import mtc_pkg::*;

    // Triangle direction of the complementary pair
    typedef enum logic {DIR_UP, DIR_DOWN} mtc_dir_t;

    // Bus decode
    logic [2:0] ch_sel;                     // Addressed channel block
    logic [3:0] idx;                        // Addressed word
    logic t1, t2, glb, ch_ok, err;
    logic glb_wr;

    // Global registers
    logic [NCH-1:0] start_r;                // Start bits
    logic [2:0] pmode_r;                    // PWM mode and cascade
    mtc_cnt_t dead_r, cdr_r, cbr_r;         // Dead time, cycle data, cycle buffer
    mtc_dir_t dir_r;
    logic [4*NCH-1:0] cap_prev_r;           // Capture pin history
    logic clk_a_r, clk_b_r;                 // External clock history

    // Channel wiring
    mtc_word_t rd_v [NCH];
    mtc_cnt_t cnt_v [NCH];
    logic [CTL_W-1:0] ctrl_v [NCH];
    logic [NCH-1:0] tick, down, cmp_strobe, sync_clr, load_en, buf_xfer;
    logic [NCH-1:0] match_a, clr_own, wrap, wr_t1_v, wr_t2_v, rd_t2_v, run;
    logic [1:0] eff_buf [NCH];
    logic [3:0] cap_evt [NCH];
    mtc_cnt_t load_val [NCH];

    // Qualified clock strobes
    logic rise_a, fall_a, rise_b, fall_b, quad_up, quad_any;
    logic casc, compl_m, rsync_m, pwm_m, stop3, upper_wr, lower_evt;
    logic c_pin_r;

    // Count strobe for a clock source choice
    function automatic logic qual(input logic [CTL_W-1:0] c, input logic r_a, input logic f_a,
                                  input logic q_any);
        case (mtc_clk_t'(c[CTL_CLK_LSB +: 2]))
            CLK_INT: qual = 1'b1;
            CLK_RISE: qual = r_a;
            CLK_BOTH: qual = r_a || f_a;
            default: qual = q_any;
        endcase
    endfunction

    // APB decode; every access completes in its first access cycle
    assign ch_sel = paddr[ADDR_CH_LSB +: 3];
    assign idx = paddr[ADDR_IDX_LSB +: 4];
    assign t1 = psel && !penable;
    assign t2 = psel && penable;
    assign glb = ch_sel == GLB_BLOCK;
    assign ch_ok = 32'(ch_sel) < NCH && idx <= IDX_LAST;
    assign err = !(ch_ok || (glb && idx <= GLB_CBR)) || paddr[1:0] != 2'b00 ||
                 32'(paddr) >= (32'(GLB_BLOCK) + 1) << ADDR_CH_LSB;
    assign pready = 1'b1;
    assign pslverr = t2 && err;
    assign glb_wr = t2 && pwrite && glb && !err;

    // Read mux, combinational so a capture in T2 is seen
    always_comb begin
        prdata = '0;
        if (t2 && !err) begin
            if (glb) begin
                case (idx)
                    GLB_START: prdata[NCH-1:0] = start_r;
                    GLB_PMODE: prdata[2:0] = pmode_r;
                    GLB_DEAD: prdata[CNT_W-1:0] = dead_r;
                    GLB_CDR: prdata[CNT_W-1:0] = cdr_r;
                    default: prdata[CNT_W-1:0] = cbr_r;
                endcase
            end else begin
                prdata = rd_v[ch_sel];
            end
        end
    end

    // Mode decode
    assign casc = pmode_r[PM_CASC];
    assign compl_m = mtc_pmode_t'(pmode_r[1:0]) == PM_COMPL;
    assign rsync_m = mtc_pmode_t'(pmode_r[1:0]) == PM_RSYNC;
    assign pwm_m = compl_m || rsync_m;
    assign stop3 = compl_m && glb_wr && idx == GLB_START && start_r[3] && !pwdata[3];

    // External clock edges and two-phase decode
    assign rise_a = ext_clk_a && !clk_a_r;
    assign fall_a = !ext_clk_a && clk_a_r;
    assign rise_b = ext_clk_b && !clk_b_r;
    assign fall_b = !ext_clk_b && clk_b_r;
    // Widths are assumed met by the source; narrower pulses are missed
    assign quad_up = (rise_a && !ext_clk_b) || (fall_a && ext_clk_b) ||
                     (rise_b && ext_clk_a) || (fall_b && !ext_clk_a);
    assign quad_any = rise_a || fall_a || rise_b || fall_b;

    // Cascade: channel 1 counts on channel 2 wrap
    assign upper_wr = wr_t2_v[2] && idx == IDX_CNT;
    assign lower_evt = casc ? wrap[2] : tick[1];
    assign run[0] = start_r[0];
    assign run[1] = start_r[1];
    assign run[2] = start_r[2];
    assign run[3] = start_r[3];
    assign run[4] = pwm_m ? start_r[3] : start_r[4];

    // Per-channel strobes
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            wr_t1_v[i] = t1 && pwrite && !err && !glb && ch_sel == 3'(i);
            wr_t2_v[i] = t2 && pwrite && !err && !glb && ch_sel == 3'(i);
            rd_t2_v[i] = t2 && !pwrite && !err && !glb && ch_sel == 3'(i);
            tick[i] = run[i] && qual(ctrl_v[i], rise_a, fall_a, quad_any);
            down[i] = 1'b0;
            cmp_strobe[i] = 1'b0;
            sync_clr[i] = mtc_clr_t'(ctrl_v[i][CTL_CLR_LSB +: 2]) == CLR_SYNC && |clr_own;
            load_en[i] = 1'b0;
            load_val[i] = CNT_ZERO;
            buf_xfer[i] = 1'b0;
            eff_buf[i] = ctrl_v[i][CTL_BUF_LSB +: 2];
            for (int k = 0; k < 4; k++)
                cap_evt[i][k] = cap_pin[4*i+k] && !cap_prev_r[4*i+k];
        end
        // Two-phase count direction only on channels 1 and 2; other channels count up on every edge
        for (int i = 1; i < 3; i++) begin
            if (mtc_clk_t'(ctrl_v[i][CTL_CLK_LSB +: 2]) == CLK_PHASE)
                down[i] = !quad_up;
        end
        if (casc) begin
            tick[1] = start_r[1] && wrap[2] && !upper_wr;
            cmp_strobe[1] = wrap[2] && upper_wr;
            down[1] = down[2];
        end
        // Internal capture sources
        if (ctrl_v[0][CTL_CAPINT])
            cap_evt[0] = cap_evt[0] | {4{lower_evt}};
        if (ctrl_v[1][CTL_CAPINT])
            cap_evt[1][1] = cap_evt[1][1] || match_a[1];
        // Channels 3 and 4 as one PWM pair
        if (pwm_m) begin
            tick[4] = run[4] && qual(ctrl_v[3], rise_a, fall_a, quad_any);
            eff_buf[3] = ctrl_v[3][CTL_BUF_LSB +: 2];
            eff_buf[4] = ctrl_v[3][CTL_BUF_LSB +: 2];
        end
        if (rsync_m) begin
            sync_clr[4] = clr_own[3];
        end
        if (compl_m) begin
            down[3] = dir_r == DIR_DOWN;
            down[4] = dir_r == DIR_DOWN;
            buf_xfer[3] = match_a[3];
            buf_xfer[4] = match_a[3];
            load_en[3] = stop3;
            load_en[4] = stop3;
            load_val[3] = dead_r;
            load_val[4] = CNT_ZERO;
        end
    end

    // Channel instances; only channel 0 forwards a T1 buffer write
    for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
        mtc_chan #(
            .NEW_ON_T1(gi == 0)
        ) u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick[gi]),
            .down(down[gi]),
            .cmp_strobe(cmp_strobe[gi]),
            .sync_clr(sync_clr[gi]),
            .load_en(load_en[gi]),
            .load_val(load_val[gi]),
            .buf_xfer(buf_xfer[gi]),
            .eff_buf(eff_buf[gi]),
            .cap_evt(cap_evt[gi]),
            .dma_ack(dma_ack[gi]),
            .wr_t1(wr_t1_v[gi]),
            .wr_t2(wr_t2_v[gi]),
            .rd_t2(rd_t2_v[gi]),
            .idx(idx),
            .wdata(pwdata),
            .rdata(rd_v[gi]),
            .cnt(cnt_v[gi]),
            .ctrl(ctrl_v[gi]),
            .match_a(match_a[gi]),
            .clr_own(clr_own[gi]),
            .wrap(wrap[gi]),
            .pin_a(timer_io_pin_a[gi]),
            .pin_b(timer_io_pin_b[gi]),
            .irq(irq[gi]),
            .dma_req(dma_req[gi])
        );
    end

    // Global registers and pin history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= '0;
            pmode_r <= '0;
            dead_r <= CNT_ZERO;
            cdr_r <= CNT_ZERO;
            cbr_r <= CNT_ZERO;
            cap_prev_r <= '0;
            clk_a_r <= 1'b0;
            clk_b_r <= 1'b0;
        end else begin
            cap_prev_r <= cap_pin;
            clk_a_r <= ext_clk_a;
            clk_b_r <= ext_clk_b;
            if (glb_wr && idx == GLB_START)
                start_r <= pwdata[NCH-1:0];
            if (glb_wr && idx == GLB_PMODE)
                pmode_r <= pwdata[2:0];
            if (glb_wr && idx == GLB_DEAD)
                dead_r <= pwdata[CNT_W-1:0];
            if (glb_wr && idx == GLB_CBR)
                cbr_r <= pwdata[CNT_W-1:0];
            // Cycle data follows its buffer at the crest
            if (compl_m && ctrl_v[3][CTL_BUF_LSB] && match_a[3])
                cdr_r <= cbr_r;
            else if (glb_wr && idx == GLB_CDR)
                cdr_r <= pwdata[CNT_W-1:0];
        end
    end

    // Triangle direction: down from the crest, up from the trough
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            dir_r <= DIR_UP;
        else if (!compl_m || stop3)
            dir_r <= DIR_UP;
        else if (dir_r == DIR_UP && match_a[3])
            dir_r <= DIR_DOWN;
        else if (dir_r == DIR_DOWN && tick[4] && cnt_v[4] == CNT_ZERO)
            dir_r <= DIR_UP;
    end

    // Reset-sync C phase: high at cycle start, low on channel 4 match A
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            c_pin_r <= 1'b0;
        else if (!rsync_m || ctrl_v[4][CTL_BUF_LSB])
            c_pin_r <= 1'b0;
        else if (clr_own[3])
            c_pin_r <= 1'b1;
        else if (match_a[4])
            c_pin_r <= 1'b0;
    end

    assign ch4_c_output_pin = c_pin_r;
endmodule

/* File: tb/mtc_core_properties.sv */
// Purpose: Port-level checks of the timer core
// Assumes: Zero-wait APB slave, one clock domain
// Notes: Attached to mtc_core by bind
module mtc_props #(parameter int NCH = 5) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mtc_pkg::ADDR_W-1:0] paddr,
    input wire mtc_pkg::mtc_word_t prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NCH-1:0] dma_ack,
    input wire logic [NCH-1:0] dma_req,
    input wire logic [NCH-1:0] irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable; // Access cycle
    wire cause0 = dma_ack[0] || (acc && pwrite); // Only ways a flag or enable drops
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_idle; !acc |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("prdata not zero outside access");
    property p_erracc; pslverr |-> acc; endproperty
    a_erracc: assert property (p_erracc) else $error("pslverr outside access");
    property p_unal; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
    a_unal: assert property (p_unal) else $error("unaligned access accepted");
    property p_unmap; acc && (paddr[11:9] != 3'h0 || paddr[8:6] > 3'h5) |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
    property p_errz; pslverr |-> prdata == 32'h0; endproperty
    a_errz: assert property (p_errz) else $error("error access returned data");
    property p_dma; $fell(dma_req[0]) |-> $past(cause0) || $past(cause0, 2); endproperty
    a_dma: assert property (p_dma) else $error("dma request dropped without cause");
    property p_irq; $fell(irq[0]) |-> $past(cause0) || $past(cause0, 2); endproperty
    a_irq: assert property (p_irq) else $error("interrupt dropped without cause");
endmodule

bind mtc_core mtc_props #(.NCH(NCH)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_ack(dma_ack), .dma_req(dma_req), .irq(irq));

/* File: tb/mtc_far_model.sv */
// Purpose: Far side: DMA acknowledge and quadrature count clocks
// Assumes: Acknowledge is one pclk pulse
// Notes: Quarter phase of 8 pclk keeps widths well above minimum
module mtc_far_model #(parameter int LAT = 3) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dma_req0,
    output logic dma_ack0,
    output logic ext_a,
    output logic ext_b,
    output int n_ack
);
    int wait_c; // Service delay so far
    logic [4:0] ph_r; // Quadrature phase counter
    assign ext_a = ph_r[4];
    assign ext_b = ph_r[4] ^ ph_r[3];
    // Serve a request late, as a slow controller would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ack0 <= 1'b0;
            wait_c <= 0;
            n_ack <= 0;
            ph_r <= 5'h00;
        end else begin
            ph_r <= ph_r + 5'h01;
            dma_ack0 <= dma_req0 && !dma_ack0 && wait_c == LAT;
            wait_c <= (dma_req0 && wait_c < LAT) ? wait_c + 1 : 0;
            if (dma_req0 && !dma_ack0 && wait_c == LAT) n_ack <= n_ack + 1;
        end
    end
endmodule

/* File: tb/mtc_core_tb.sv */
// Purpose: Self-checking bench of the timer core
// Assumes: Zero-wait APB, pclk 200 MHz
// Notes: Each scenario judges its own results
module mtc_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mtc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [ADDR_W-1:0] paddr = 12'h000;
    mtc_word_t pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ack0, ea, eb, c4;
    logic [19:0] cap = 20'h00000; // Capture pins
    logic [4:0] dreq, irq, pa, pb;
    int n_fail = 0, comparisons = 0, cyc = 0, nack;
    initial forever #2.5 pclk = ~pclk;
    mtc_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk_a(ea), .ext_clk_b(eb), .cap_pin(cap), .dma_ack({4'h0, ack0}), .dma_req(dreq),
        .irq(irq), .timer_io_pin_a(pa), .timer_io_pin_b(pb), .ch4_c_output_pin(c4));
    mtc_far_model far_u (.pclk(pclk), .presetn(presetn), .dma_req0(dreq[0]), .dma_ack0(ack0),
        .ext_a(ea), .ext_b(eb), .n_ack(nack));
    task automatic chk(string what, mtc_word_t exp, mtc_word_t got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    // One APB transfer; capture strobe rides on the access cycle
    task automatic apb(logic w, logic [11:0] a, mtc_word_t d, logic [19:0] cv = 20'h0);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        cap <= cv;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Period, pin toggle, interrupt and flag clear
    task automatic t_period();
        int t;
        logic v;
        apb(1, 12'h014, 32'h4);
        apb(1, 12'h004, 32'h3);
        apb(1, 12'h008, 32'h1);
        apb(1, 12'h000, 32'h400);
        apb(1, 12'h140, 32'h1);
        for (int k = 0; k < 2; k++) begin
            v = pa[0];
            t = 0;
            while (pa[0] === v && t < 50) begin
                @(posedge pclk);
                t++;
            end
        end
        chk("period", 32'h5, 32'(t));
        chk("irq", 32'h1, {31'h0, irq[0]});
        apb(1, 12'h140, 32'h0);
        apb(0, 12'h00c, 32'h0);
        chk("flag", 32'h1, rd & 32'h1);
        apb(1, 12'h00c, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq off", 32'h0, {31'h0, irq[0]});
    endtask
    // Write against increment, then captures against bus access
    task automatic t_race();
        apb(1, 12'h140, 32'h4);
        apb(1, 12'h090, 32'hff00);
        apb(0, 12'h090, 32'h0);
        chk("count", 32'hff02, rd);
        apb(1, 12'h000, 32'h1010);
        apb(1, 12'h010, 32'h55);
        apb(1, 12'h014, 32'hab, 20'h1);
        apb(0, 12'h014, 32'h0);
        chk("cap vs write", 32'h55, rd);
        apb(1, 12'h010, 32'h66);
        apb(0, 12'h014, 32'h0, 20'h1);
        chk("cap vs read", 32'h66, rd);
        apb(1, 12'h010, 32'h99);
        apb(1, 12'h01c, 32'h77, 20'h1);
        apb(0, 12'h01c, 32'h0);
        chk("buffer", 32'h66, rd);
    endtask
    // DMA service and an unmapped read
    task automatic t_misc();
        apb(1, 12'h000, 32'h400);
        apb(1, 12'h014, 32'ha0);
        apb(1, 12'h008, 32'h80);
        apb(1, 12'h144, 32'h4);
        apb(1, 12'h140, 32'h7);
        repeat (300) @(posedge pclk);
        chk("dma acks", 32'h1, {31'h0, nack > 0});
        apb(0, 12'h050, 32'h0);
        chk("cascade", 32'h1, rd);
        apb(0, 12'h1c0, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        chk("err data", 32'h0, rd);
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_period();
        t_race();
        t_misc();
        print_verdict();
    end
endmodule
